/* src/bwl_config.v */
// burst-wrap and read-latency configuration with its serial command port
// assumes sck, cs_n, si and the reset pin are asynchronous to core_clk,
// sck at most an eighth of core_clk, spi mode 0, single-bit commands
`default_nettype none
`include "bwl_regs.vh"

module bwl_config (
  input wire core_clk,
  input wire resetn,
  input wire ce,
  input wire hw_reset_pin_n,
  input wire soft_reset,
  input wire spi_sck,
  input wire spi_cs_n,
  input wire spi_si,
  output reg spi_so,
  output reg spi_so_oe,
  input wire [2:0] array_read_class,
  output reg [3:0] array_dummy_cycles,
  output reg array_wrap_on,
  output reg [1:0] array_wrap_len,
  output reg [7:0] boot_cfg,
  output reg [7:0] live_cfg,
  output reg write_enabled
);

  localparam ST_IDLE = 3'd0;
  localparam ST_CMD = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_DUMMY = 3'd3;
  localparam ST_IN = 3'd4;
  localparam ST_OUT = 3'd5;
  localparam ST_SKIP = 3'd6;

  // pin synchronisers: sck, cs_n, si, reset pin
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg sck_d;
  reg cs_n_d;

  wire sck_s;
  wire cs_n_s;
  wire si_s;
  wire hw_rst_s_n;
  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;
  wire any_reset;

  reg [2:0] state;
  reg [4:0] bit_cnt;
  reg [7:0] opcode;
  reg [23:0] addr_sr;
  reg [7:0] in_sr;
  reg [7:0] out_sr;
  reg [1:0] byte_idx;
  reg [3:0] dummy_left;
  reg [7:0] pend_boot;
  reg pend_boot_v;
  reg [7:0] pend_live;
  reg pend_live_v;

  wire [7:0] next_in;
  wire [23:0] next_addr;
  wire [7:0] next_cfg_w;
  reg [7:0] addr_data;
  wire [3:0] reg_read_dummy;
  wire [3:0] arr_dummy;
  wire arr_wrap_on;
  wire [1:0] arr_wrap_len;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // idle levels: reset pin high, si low, cs_n high, sck low
      sync1 <= 4'ha;
      sync2 <= 4'ha;
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else if (ce) begin
      sync1 <= {hw_reset_pin_n, spi_si, spi_cs_n, spi_sck};
      sync2 <= sync1;
      sck_d <= sck_s;
      cs_n_d <= cs_n_s;
    end
  end

  assign sck_s = sync2[0];
  assign cs_n_s = sync2[1];
  assign si_s = sync2[2];
  assign hw_rst_s_n = sync2[3];
  assign sck_rise = sck_s && !sck_d && !cs_n_s;
  assign sck_fall = !sck_s && sck_d && !cs_n_s;
  assign cs_fall = !cs_n_s && cs_n_d;
  assign cs_rise = cs_n_s && !cs_n_d;
  assign any_reset = !hw_rst_s_n || soft_reset;

  assign next_in = {in_sr[6:0], si_s};
  assign next_addr = {addr_sr[22:0], si_s};
  // reserved bit forced to zero on every write
  assign next_cfg_w = next_in & `BWL_WR_MASK;

  // read-any-register data by address; unmapped reads as zero
  always @* begin
    case (next_addr)
      `BWL_ADDR_BOOT: addr_data = boot_cfg;
      `BWL_ADDR_LIVE: addr_data = live_cfg;
      default: addr_data = 8'h00;
    endcase
  end

  // register read latency follows the live code
  bwl_latency u_reg_lat (
    .cfg(live_cfg),
    .read_class(`BWL_CLS_VAR_SEQ),
    .dummy_cycles(reg_read_dummy),
    .wrap_on(),
    .wrap_len()
  );

  // array read path decoded from the live copy only
  bwl_latency u_arr_lat (
    .cfg(live_cfg),
    .read_class(array_read_class),
    .dummy_cycles(arr_dummy),
    .wrap_on(arr_wrap_on),
    .wrap_len(arr_wrap_len)
  );

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      array_dummy_cycles <= `BWL_DUMMY_NONE;
      array_wrap_on <= 1'b0;
      array_wrap_len <= 2'b00;
    end else if (ce) begin
      array_dummy_cycles <= arr_dummy;
      array_wrap_on <= arr_wrap_on;
      array_wrap_len <= arr_wrap_len;
    end
  end

  // command sequencer
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      bit_cnt <= 5'd0;
      opcode <= 8'h00;
      addr_sr <= 24'h000000;
      in_sr <= 8'h00;
      out_sr <= 8'h00;
      byte_idx <= 2'd0;
      dummy_left <= 4'd0;
      pend_boot <= 8'h00;
      pend_boot_v <= 1'b0;
      pend_live <= 8'h00;
      pend_live_v <= 1'b0;
      write_enabled <= 1'b0;
      spi_so <= 1'b0;
      spi_so_oe <= 1'b0;
    end else if (ce) begin
      if (any_reset) begin
        state <= ST_IDLE;
        bit_cnt <= 5'd0;
        pend_boot_v <= 1'b0;
        pend_live_v <= 1'b0;
        write_enabled <= 1'b0;
        spi_so_oe <= 1'b0;
      end else if (cs_rise) begin
        // frame end: writes from this frame commit now
        state <= ST_IDLE;
        spi_so_oe <= 1'b0;
        pend_boot_v <= 1'b0;
        pend_live_v <= 1'b0;
        if (opcode == `BWL_OP_WRITE_REGS || opcode == `BWL_OP_WRITE_ANY) begin
          write_enabled <= 1'b0;
        end
      end else if (cs_fall) begin
        state <= ST_CMD;
        bit_cnt <= 5'd0;
        byte_idx <= 2'd0;
        opcode <= 8'h00;
        pend_boot_v <= 1'b0;
        pend_live_v <= 1'b0;
      end else if (sck_fall) begin
        if (state == ST_OUT) begin
          // data only after the last command rise (read-config) or the last dummy rise (read-any)
          spi_so <= out_sr[7];
          spi_so_oe <= 1'b1;
          out_sr <= {out_sr[6:0], out_sr[7]};
        end
      end else if (sck_rise) begin
        case (state)
          ST_CMD: begin
            in_sr <= next_in;
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == `BWL_CMD_LAST) begin
              bit_cnt <= 5'd0;
              opcode <= next_in;
              case (next_in)
                `BWL_OP_READ_CFG: begin
                  out_sr <= live_cfg;
                  state <= ST_OUT;
                end
                `BWL_OP_NV_NV_WRITE_ENABLE_CMD: begin
                  write_enabled <= 1'b1;
                  state <= ST_SKIP;
                end
                `BWL_OP_READ_ANY,
                `BWL_OP_WRITE_ANY: state <= ST_ADDR;
                `BWL_OP_WRITE_REGS,
                `BWL_OP_SET_BURST: state <= ST_IN;
                default: state <= ST_SKIP;
              endcase
            end
          end
          ST_ADDR: begin
            addr_sr <= next_addr;
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == `BWL_ADDR_LAST) begin
              bit_cnt <= 5'd0;
              if (opcode == `BWL_OP_READ_ANY) begin
                out_sr <= addr_data;
                dummy_left <= reg_read_dummy;
                state <= ST_DUMMY;
              end else begin
                state <= ST_IN;
              end
            end
          end
          ST_DUMMY: begin
            dummy_left <= dummy_left - 4'd1;
            if (dummy_left == 4'd1) begin
              state <= ST_OUT;
            end
          end
          ST_IN: begin
            in_sr <= next_in;
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == `BWL_BYTE_LAST) begin
              bit_cnt <= 5'd0;
              byte_idx <= byte_idx + 2'd1;
              case (opcode)
                `BWL_OP_WRITE_REGS: begin
                  // only the configuration byte lands here; boot copy only
                  if (byte_idx == `BWL_WRR_CFG_BYTE) begin
                    state <= ST_SKIP;
                    if (write_enabled) begin
                      pend_boot <= next_cfg_w;
                      pend_boot_v <= 1'b1;
                    end
                  end
                end
                `BWL_OP_SET_BURST: begin
                  pend_live <= next_cfg_w;
                  pend_live_v <= 1'b1;
                  state <= ST_SKIP;
                end
                `BWL_OP_WRITE_ANY: begin
                  state <= ST_SKIP;
                  if (write_enabled && addr_sr == `BWL_ADDR_BOOT) begin
                    pend_boot <= next_cfg_w;
                    pend_boot_v <= 1'b1;
                  end
                  if (write_enabled && addr_sr == `BWL_ADDR_LIVE) begin
                    pend_live <= next_cfg_w;
                    pend_live_v <= 1'b1;
                  end
                end
                default: state <= ST_SKIP;
              endcase
            end
          end
          ST_OUT: state <= ST_OUT;
          ST_SKIP: state <= ST_SKIP;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // configuration copies
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      boot_cfg <= `BWL_BOOT_RESET;
      live_cfg <= `BWL_BOOT_RESET;
    end else if (ce) begin
      if (any_reset) begin
        live_cfg <= boot_cfg;
      end else if (cs_rise) begin
        if (pend_boot_v) begin
          boot_cfg <= pend_boot;
        end
        if (pend_live_v) begin
          live_cfg <= pend_live;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* src/bwl_latency.v */
// latency and wrap decode for one read command class
// assumes cfg is the live copy, stable for the whole read
`default_nettype none
`include "bwl_regs.vh"

module bwl_latency (
  input wire [7:0] cfg,
  input wire [2:0] read_class,
  output reg [3:0] dummy_cycles,
  output wire wrap_on,
  output wire [1:0] wrap_len
);

  wire [3:0] lat_code;

  assign lat_code = cfg[`BWL_LAT_HI:`BWL_LAT_LO];

  always @* begin
    case (read_class)
      `BWL_CLS_FIXED: dummy_cycles = `BWL_DUMMY_NONE;
      `BWL_CLS_ONE: dummy_cycles = `BWL_DUMMY_ONE;
      // security-region and read-any reads follow the code too
      `BWL_CLS_VAR_SEQ,
      `BWL_CLS_VAR_WRAP,
      `BWL_CLS_REG: begin
        // code zero stands for eight cycles
        if (lat_code == 4'h0) begin
          dummy_cycles = `BWL_DUMMY_CODE0;
        end else begin
          dummy_cycles = lat_code;
        end
      end
      default: dummy_cycles = `BWL_DUMMY_NONE;
    endcase
  end

  // wrap only on wrap-capable array reads, active low enable
  assign wrap_on = (read_class == `BWL_CLS_VAR_WRAP) && !cfg[`BWL_WE_BIT];
  assign wrap_len = cfg[`BWL_WL_HI:`BWL_WL_LO];

endmodule
`default_nettype wire

/* src/bwl_regs.vh */
// constants of the burst-wrap and read-latency configuration block
// assumes inclusion by bare name from the design files under src/
`ifndef BWL_REGS_VH
`define BWL_REGS_VH

// opcodes as seen on the serial link
`define BWL_OP_READ_CFG 8'h33
`define BWL_OP_WRITE_REGS 8'h01
`define BWL_OP_READ_ANY 8'h65
`define BWL_OP_WRITE_ANY 8'h71
`define BWL_OP_SET_BURST 8'h77
`define BWL_OP_NV_NV_WRITE_ENABLE_CMD 8'h06

// addresses used by the read-any and write-any register commands
`define BWL_ADDR_BOOT 24'h000004
`define BWL_ADDR_LIVE 24'h800004

// field layout, shared by the boot and the live copy
`define BWL_RSV_BIT 7
`define BWL_WL_HI 6
`define BWL_WL_LO 5
`define BWL_WE_BIT 4
`define BWL_LAT_HI 3
`define BWL_LAT_LO 0
`define BWL_WR_MASK 8'h7f
`define BWL_BOOT_RESET 8'h78

// position of the configuration byte within a write-registers frame
`define BWL_WRR_CFG_BYTE 2'd3

// read command classes presented by the array read engine
`define BWL_CLS_FIXED 3'd0
`define BWL_CLS_ONE 3'd1
`define BWL_CLS_VAR_SEQ 3'd2
`define BWL_CLS_VAR_WRAP 3'd3
`define BWL_CLS_REG 3'd4

// dummy cycle counts
`define BWL_DUMMY_NONE 4'd0
`define BWL_DUMMY_ONE 4'd1
`define BWL_DUMMY_CODE0 4'd8

// serial field lengths, as last bit index
`define BWL_CMD_LAST 5'd7
`define BWL_ADDR_LAST 5'd23
`define BWL_BYTE_LAST 5'd7

`endif

/* testbench/bwl_host.sv */
// host model driving the serial link in mode 0
// assumes sck of eight core clocks, msb first
`default_nettype none
module bwl_host (
  input wire logic core_clk,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_si,
  input wire logic spi_so
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // so read just before the next fall, where it still stands
  // 200 ns sck period, legal for every code and data rate
  task automatic bit_io(input logic b, output logic s);
    spi_sck <= 1'b0;
    spi_si <= b;
    tick(4);
    spi_sck <= 1'b1;
    tick(4);
    s = spi_so;
  endtask
  task automatic frame(input logic [7:0] op, input logic [31:0] tx, input int ntx, input int ndum,
    input int nrx, output logic [7:0] rx);
    logic s;
    spi_cs_n <= 1'b0;
    tick(4);
    for (int i = 7; i >= 0; i--) bit_io(op[i], s);
    for (int i = ntx - 1; i >= 0; i--) bit_io(tx[i], s);
    for (int i = 0; i < ndum; i++) bit_io(i[0], s);
    rx = 8'h00;
    for (int i = 0; i < nrx; i++) begin
      bit_io(1'b0, s);
      rx = {rx[6:0], s};
    end
    spi_sck <= 1'b0;
    tick(4);
    spi_cs_n <= 1'b1;
    spi_si <= ~spi_si;
    tick(10);
  endtask
endmodule
`default_nettype wire

/* testbench/bwl_monitor.sv */
// assertions on the ports of the configuration block
// assumes bound onto bwl_config, single clock domain
`default_nettype none
module bwl_monitor (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic soft_reset,
  input wire logic spi_cs_n,
  input wire logic spi_so_oe,
  input wire logic [2:0] array_read_class,
  input wire logic [3:0] array_dummy_cycles,
  input wire logic array_wrap_on,
  input wire logic [1:0] array_wrap_len,
  input wire logic [7:0] boot_cfg,
  input wire logic [7:0] live_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_RSV_ZERO: assert property (!boot_cfg[7] && !live_cfg[7])
    else $error("reserved bit set");
  AST_DUMMY_ONE: assert property ((ce && array_read_class == 3'd1) |=> array_dummy_cycles == 4'd1)
    else $error("one-dummy class wrong");
  AST_DUMMY_VAR: assert property ((ce && (array_read_class[2:1] == 2'b01 || array_read_class == 3'd4)) |=>
    array_dummy_cycles == (($past(live_cfg[3:0]) == 4'd0) ? 4'd8 : $past(live_cfg[3:0])))
    else $error("variable dummy wrong");
  AST_WRAP_ON: assert property (ce |=>
    array_wrap_on == ($past(array_read_class) == 3'd3 && !$past(live_cfg[4])))
    else $error("wrap enable wrong");
  AST_WRAP_LEN: assert property (ce |=> array_wrap_len == $past(live_cfg[6:5]))
    else $error("wrap length wrong");
  AST_SOFT_LOAD: assert property ((ce && soft_reset) |=> live_cfg == $past(boot_cfg))
    else $error("reset did not load live");
  AST_NV_ISOLATE: assert property ($changed(boot_cfg) |-> $stable(live_cfg))
    else $error("boot write moved live");
  AST_LIVE_CS: assert property ($changed(live_cfg) |-> spi_cs_n || $past(soft_reset))
    else $error("live changed in frame");
  AST_OE_IDLE: assert property (spi_cs_n [*5] |-> !spi_so_oe)
    else $error("output enabled while idle");
  cover property (ce && soft_reset);
  cover property (array_wrap_on);
  cover property ($changed(boot_cfg));
endmodule
bind bwl_config bwl_monitor u_mon (.core_clk(core_clk), .resetn(resetn), .ce(ce), .soft_reset(soft_reset),
  .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe), .array_read_class(array_read_class),
  .array_dummy_cycles(array_dummy_cycles), .array_wrap_on(array_wrap_on),
  .array_wrap_len(array_wrap_len), .boot_cfg(boot_cfg), .live_cfg(live_cfg));
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the configuration block
// assumes bwl_host as the serial master
`default_nettype none
`include "bwl_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, ce, hw_reset_pin_n, soft_reset, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe;
  logic write_enabled, array_wrap_on;
  logic [2:0] array_read_class;
  logic [3:0] array_dummy_cycles;
  logic [1:0] array_wrap_len;
  logic [7:0] boot_cfg, live_cfg, rx;
  int err_count, tests_run, boot_m, live_m, dum;
  bwl_config u_dut (.core_clk(core_clk), .resetn(resetn), .ce(ce), .hw_reset_pin_n(hw_reset_pin_n),
    .soft_reset(soft_reset), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .array_read_class(array_read_class), .array_dummy_cycles(array_dummy_cycles),
    .array_wrap_on(array_wrap_on), .array_wrap_len(array_wrap_len), .boot_cfg(boot_cfg),
    .live_cfg(live_cfg), .write_enabled(write_enabled));
  bwl_host u_host (.core_clk(core_clk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input int exp);
    tests_run++;
    if (got !== 8'(exp)) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, 8'(exp));
    end
  endtask
  task automatic give_verdict();
    $display("compares=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] op, input logic [31:0] tx, input int ntx);
    u_host.frame(op, tx, ntx, 0, 0, rx);
  endtask
  task automatic rd65(input logic [23:0] a, input int exp);
    dum = ((live_m & 15) == 0) ? 8 : (live_m & 15);
    u_host.frame(`BWL_OP_READ_ANY, {8'h00, a}, 24, dum, 8, rx);
    chk(rx, exp);
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    give_verdict();
  end
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    hw_reset_pin_n = 1'b1;
    soft_reset = 1'b0;
    array_read_class = 3'd0;
    dum = $urandom(48589);
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge core_clk);
    boot_m = 'h78;
    live_m = 'h78;
    chk(boot_cfg, boot_m);
    chk(live_cfg, live_m);
    for (int k = 0; k < 6; k++) begin
      live_m = (k == 0) ? 'hd0 : (k == 1) ? 'h2a : $urandom & 'hff;
      xfer(`BWL_OP_SET_BURST, live_m, 8);
      live_m &= 'h7f;
      u_host.frame(`BWL_OP_READ_CFG, 32'h0, 0, 0, 8, rx);
      chk(rx, live_m);
      chk(boot_cfg, boot_m);
      for (int c = 0; c < 5; c++) begin
        array_read_class <= 3'(c);
        repeat (2) @(posedge core_clk);
        dum = (c == 0) ? 0 : (c == 1) ? 1 : ((live_m & 15) == 0) ? 8 : (live_m & 15);
        chk(8'(array_dummy_cycles), dum);
        chk(8'(array_wrap_on), (c == 3) && !live_m[4]);
        chk(8'(array_wrap_len), (live_m >> 5) & 3);
      end
      rd65(`BWL_ADDR_LIVE, live_m);
    end
    xfer(`BWL_OP_WRITE_REGS, 32'h0000003c, 32);
    chk(boot_cfg, boot_m);
    xfer(`BWL_OP_NV_NV_WRITE_ENABLE_CMD, 32'h0, 0);
    chk(8'(write_enabled), 1);
    xfer(`BWL_OP_WRITE_REGS, 32'h000000b3, 32);
    boot_m = 'h33;
    chk(boot_cfg, boot_m);
    chk(live_cfg, live_m);
    chk(8'(write_enabled), 0);
    rd65(`BWL_ADDR_BOOT, boot_m);
    rd65(24'h000010, 0);
    xfer(`BWL_OP_NV_NV_WRITE_ENABLE_CMD, 32'h0, 0);
    xfer(`BWL_OP_WRITE_ANY, {`BWL_ADDR_LIVE, 8'hc5}, 32);
    live_m = 'h45;
    chk(live_cfg, live_m);
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(live_cfg, boot_m);
    xfer(`BWL_OP_SET_BURST, 32'h0000000f, 8);
    hw_reset_pin_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    hw_reset_pin_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(live_cfg, boot_m);
    ce <= 1'b0;
    array_read_class <= 3'd1;
    repeat (3) @(posedge core_clk);
    chk(8'(array_dummy_cycles), boot_m & 15);
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(8'(array_dummy_cycles), 1);
    give_verdict();
  end
endmodule
`default_nettype wire
